// >>> src/link_status_map.svh
// Purpose: register offsets, field positions and reset values of the link status block
// Assumes: byte-wide registers reached over a plain address/strobe port
// Notes: definitions only
`ifndef LINK_STATUS_MAP_SVH
`define LINK_STATUS_MAP_SVH

`define ADDR_W 12
`define DATA_W 8
`define OFF_SERIAL_LINK_STATUS 12'h0208
`define OFF_CHANNEL_POWER_DOWN 12'h0209
`define OFF_LINK_CONTROL 12'h020C
`define BIT_LINK_UP 6
`define BIT_SYNC_LEVEL 5
`define BIT_PHASE_SHIFTED 4
`define BIT_SET_BY_SYSREF 3
`define BIT_PLL_LOCKED 2
`define BIT_CHAN_B_OFF 1
`define BIT_CHAN_A_OFF 0
`define BIT_LINK_ENABLE 0
`define RESET_POWER_DOWN 8'h00
`define RESET_LINK_CONTROL 8'h00
`define RESET_PD_FIELD 2'h0
`define RESET_LINK_ENABLE 1'h0
`define RESET_SYNC_LEVEL 1'h1
`define READ_ZERO 8'h00
`define PD_FIELD_W 2

`endif

// >>> src/link_status_pkg.sv
// Purpose: shared types of the link status block
// Assumes: constants come from link_status_map.svh
// Notes: nothing here holds a number of its own
`include "link_status_map.svh"

package link_status_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic link_up;
    logic sync_n;
    logic phase_shift_evt;
    logic sysref_align_evt;
    logic pll_locked;
  } link_obs_t;

  typedef struct packed {
    logic chan_a_on;
    logic chan_b_on;
    logic subsys_on;
    logic link_b_samples_valid;
  } power_ctl_t;

  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_WAIT_SYSREF,
    ALIGN_DONE
  } align_state_t;

endpackage

// >>> src/sticky_flag.sv
// Purpose: one hardware-set, write-one-to-clear flag
// Assumes: set and clear are single-cycle terms
// Notes: set wins over clear in the same cycle
module sticky_flag (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic set, // hardware event
  input wire logic clear, // software write of one
  output logic flag // sticky value
);
  typedef struct packed {
    logic flag;
  } sticky_state_t;

  sticky_state_t state;
  sticky_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (set)
    begin
      next_state.flag = 1'b1;
    end
    else if (clear)
    begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign flag = state.flag;
endmodule // sticky_flag

// >>> src/power_gate.sv
// Purpose: derive channel and subsystem power from the power-down field
// Assumes: bound digital channels follow their converter channel
// Notes: registered outputs
`include "link_status_map.svh"

module power_gate (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [`PD_FIELD_W-1:0] power_down, // chan_b_power_off, chan_a_power_off
  input wire logic b_on_link_a, // link A carries B samples
  output link_status_pkg::power_ctl_t power // gated power controls
);
  typedef struct packed {
    link_status_pkg::power_ctl_t power;
  } gate_state_t;

  gate_state_t state;
  gate_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.power.chan_a_on = !power_down[`BIT_CHAN_A_OFF];
    next_state.power.chan_b_on = !power_down[`BIT_CHAN_B_OFF];
    next_state.power.subsys_on = !(&power_down);
    // link A keeps running; B slots are marked invalid when B is off
    next_state.power.link_b_samples_valid = !(b_on_link_a && power_down[`BIT_CHAN_B_OFF]);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign power = state.power;
endmodule // power_gate

// >>> src/link_status_regs.sv
// Purpose: serial link status and channel power-down registers
// Assumes: inputs synchronous to clk_sys; one-cycle read/write strobes
// Notes: read data valid the cycle after the read strobe only
//
// Added by the designer: the plain strobed port.
`include "link_status_map.svh"

module link_status_regs (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [`ADDR_W-1:0] reg_addr, // register address
  input wire logic [`DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [`DATA_W-1:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic link_up, // serial link established
  input wire logic sync_n, // receiver SYNC~ level, low asserted
  input wire logic sysref_evt, // SYSREF event pulse
  input wire logic phase_shift_evt, // frame clock frame_clock_phase_shifted pulse
  input wire logic pll_locked, // serializer PLL lock
  input wire logic b_on_link_a, // link A carries B samples
  output logic serial_link_enable, // serial encoder enable
  output logic chan_a_power_off, // channel A off
  output logic chan_b_power_off, // channel B off
  output logic chan_a_on, // channel A and bound digital channels powered
  output logic chan_b_on, // channel B and bound digital channels powered
  output logic subsys_on, // serial subsystem, PLL and frame clock powered
  output logic link_b_samples_valid // B samples on link A defined
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [`DATA_W-1:0] rdata;
    logic [`PD_FIELD_W-1:0] power_down;
    logic link_enable;
    link_status_pkg::align_state_t align;
    link_status_pkg::link_obs_t obs;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;
  link_status_pkg::reg_req_t req;
  link_status_pkg::power_ctl_t power;
  logic frame_clock_phase_shifted;
  logic frame_clock_set_by_sysref;
  logic wr_status;
  logic clr_shifted;
  logic clr_sysref;
  logic align_set;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_status = req.wr && (req.addr == `OFF_SERIAL_LINK_STATUS);
  assign clr_shifted = wr_status && req.wdata[`BIT_PHASE_SHIFTED];
  assign clr_sysref = wr_status && req.wdata[`BIT_SET_BY_SYSREF];
  assign align_set = (state.align == link_status_pkg::ALIGN_WAIT_SYSREF) && sysref_evt;

  // ==========================================================
  // sticky alignment flags
  sticky_flag u_phase_shifted (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .set(state.obs.phase_shift_evt),
    .clear(clr_shifted),
    .flag(frame_clock_phase_shifted)
  );

  sticky_flag u_set_by_sysref (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .set(align_set),
    .clear(clr_sysref),
    .flag(frame_clock_set_by_sysref)
  );

  // ==========================================================
  // power gating
  power_gate u_power (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .power_down(state.power_down),
    .b_on_link_a(b_on_link_a),
    .power(power)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    next_state.obs.link_up = link_up && power.subsys_on;
    next_state.obs.sync_n = sync_n;
    next_state.obs.phase_shift_evt = phase_shift_evt && power.subsys_on;
    next_state.obs.sysref_align_evt = align_set;
    next_state.obs.pll_locked = pll_locked && power.subsys_on;
    // first SYSREF after enable only; re-arms when the encoder is re-enabled
    unique case (state.align)
      link_status_pkg::ALIGN_IDLE:
      begin
        if (state.link_enable)
          next_state.align = link_status_pkg::ALIGN_WAIT_SYSREF;
      end
      link_status_pkg::ALIGN_WAIT_SYSREF:
      begin
        if (!state.link_enable)
          next_state.align = link_status_pkg::ALIGN_IDLE;
        else if (sysref_evt)
          next_state.align = link_status_pkg::ALIGN_DONE;
      end
      link_status_pkg::ALIGN_DONE:
      begin
        if (!state.link_enable)
          next_state.align = link_status_pkg::ALIGN_IDLE;
      end
      default:
      begin
        next_state.align = link_status_pkg::ALIGN_IDLE;
      end
    endcase
    if (req.wr)
    begin
      unique case (req.addr)
        `OFF_CHANNEL_POWER_DOWN:
        begin
          // takes effect as written; clearing the link enable first is up to software
          next_state.power_down = req.wdata[`PD_FIELD_W-1:0];
        end
        `OFF_LINK_CONTROL:
        begin
          next_state.link_enable = req.wdata[`BIT_LINK_ENABLE];
        end
        default:
        begin
          next_state.power_down = state.power_down;
        end
      endcase
    end
    next_state.rdata = `READ_ZERO;
    if (req.rd)
    begin
      unique case (req.addr)
        `OFF_SERIAL_LINK_STATUS:
        begin
          next_state.rdata[`BIT_LINK_UP] = state.obs.link_up;
          next_state.rdata[`BIT_SYNC_LEVEL] = state.obs.sync_n;
          next_state.rdata[`BIT_PHASE_SHIFTED] = frame_clock_phase_shifted;
          next_state.rdata[`BIT_SET_BY_SYSREF] = frame_clock_set_by_sysref;
          next_state.rdata[`BIT_PLL_LOCKED] = state.obs.pll_locked;
        end
        `OFF_CHANNEL_POWER_DOWN:
        begin
          next_state.rdata[`PD_FIELD_W-1:0] = state.power_down;
        end
        `OFF_LINK_CONTROL:
        begin
          next_state.rdata[`BIT_LINK_ENABLE] = state.link_enable;
        end
        default:
        begin
          next_state.rdata = `READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.rdata <= `READ_ZERO;
      state.power_down <= `RESET_PD_FIELD;
      state.link_enable <= `RESET_LINK_ENABLE;
      state.align <= link_status_pkg::ALIGN_IDLE;
      state.obs.sync_n <= `RESET_SYNC_LEVEL;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = state.rdata;
  assign serial_link_enable = state.link_enable;
  assign chan_a_power_off = state.power_down[`BIT_CHAN_A_OFF];
  assign chan_b_power_off = state.power_down[`BIT_CHAN_B_OFF];
  assign chan_a_on = power.chan_a_on;
  assign chan_b_on = power.chan_b_on;
  assign subsys_on = power.subsys_on;
  assign link_b_samples_valid = power.link_b_samples_valid;
endmodule // link_status_regs

// >>> tb/link_checker.sv
// Purpose: port-level assertions of the link status block
// Assumes: bound to link_status_regs
// Notes: status reads lag the inputs by two stages
`include "link_status_map.svh"

module link_checker (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [`ADDR_W-1:0] reg_addr, // address
  input wire logic [`DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [`DATA_W-1:0] reg_rdata, // read data
  input wire logic link_up, // link up
  input wire logic sync_n, // sync level
  input wire logic sysref_evt, // sysref pulse
  input wire logic phase_shift_evt, // realign pulse
  input wire logic pll_locked, // pll lock
  input wire logic b_on_link_a, // b data on link a
  input wire logic serial_link_enable, // encoder on
  input wire logic chan_a_power_off, // a off field
  input wire logic chan_b_power_off, // b off field
  input wire logic chan_a_on, // a powered
  input wire logic chan_b_on, // b powered
  input wire logic subsys_on, // subsystem powered
  input wire logic link_b_samples_valid // b samples defined
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // properties
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence rd_st;
    $past(reg_rd) && $past(reg_addr) == `OFF_SERIAL_LINK_STATUS && $past(subsys_on)
      && $past(subsys_on, 2) && $past(subsys_on, 3);
  endsequence
  sequence shift_rd;
    phase_shift_evt && subsys_on ##3 reg_rd && reg_addr == `OFF_SERIAL_LINK_STATUS;
  endsequence
  link_state_a: assert property (rd_st |-> reg_rdata[6] == $past(link_up, 2)) else $error("link bit");
  sync_level_a: assert property (rd_st |-> reg_rdata[5] == $past(sync_n, 2)) else $error("sync bit");
  pll_lock_a: assert property (rd_st |-> reg_rdata[2] == $past(pll_locked, 2)) else $error("pll bit");
  shift_set_a: assert property (shift_rd |=> reg_rdata[4]) else $error("shift flag");
  b_power_a: assert property (chan_b_power_off |=> !chan_b_on) else $error("b power");
  a_power_a: assert property ($past(reset_n) |-> chan_a_on == !$past(chan_a_power_off)) else $error("a power");
  subsys_power_a: assert property ($past(chan_a_power_off) && $past(chan_b_power_off) |-> !subsys_on)
    else $error("subsystem power");
  link_a_keep_a: assert property ($past(chan_b_power_off) && !$past(chan_a_power_off) |-> subsys_on && chan_a_on
    && !(link_b_samples_valid && $past(b_on_link_a))) else $error("link a keep");
  pd_write_a: assert property ($past(reg_wr) && $past(reg_addr) == `OFF_CHANNEL_POWER_DOWN
    |-> {chan_b_power_off, chan_a_power_off} == $past(reg_wdata[1:0])) else $error("pd write");
endmodule // link_checker

// >>> tb/rx_model.sv
// Purpose: serial receiver seen from the status block
// Assumes: sync request drops a few cycles after encoder enable
// Notes: events are pulsed by the bench through pulse
module rx_model (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic serial_link_enable, // encoder on
  output logic link_up, // link established
  output logic sync_n, // sync request, low asserted
  output logic sysref_evt, // sysref pulse
  output logic phase_shift_evt, // realign pulse
  output logic pll_locked, // pll lock
  output logic b_on_link_a // link a carries b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // receiver
  logic [2:0] wait_cnt;
  initial
  begin
    pll_locked = 1'h1;
    b_on_link_a = 1'h0;
    sysref_evt = 1'h0;
    phase_shift_evt = 1'h0;
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wait_cnt <= 3'h0;
    else if (!serial_link_enable)
      wait_cnt <= 3'h0;
    else if (wait_cnt != 3'h4)
      wait_cnt <= wait_cnt + 3'h1;
  end
  // sync request held until the encoder has run a while
  assign sync_n = (wait_cnt == 3'h4);
  assign link_up = sync_n && pll_locked;
  task automatic pulse(input logic sysref);
    @(posedge clk_sys);
    sysref_evt <= sysref;
    phase_shift_evt <= !sysref;
    @(posedge clk_sys);
    sysref_evt <= 1'h0;
    phase_shift_evt <= 1'h0;
    // realign flag needs one more stage before a read can see it
    @(posedge clk_sys);
  endtask
endmodule // rx_model

// >>> tb/testbench.sv
// Purpose: self-checking bench of the link status block
// Assumes: rx_model on the serial side
// Notes: registers reached through the strobe port
`include "link_status_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // signals
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [`ADDR_W-1:0] reg_addr = 12'h0000;
  logic [`DATA_W-1:0] reg_wdata = 8'h00;
  logic [`DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic link_up, sync_n, sysref_evt, phase_shift_evt, pll_locked, b_on_link_a;
  logic serial_link_enable, chan_a_power_off, chan_b_power_off;
  logic chan_a_on, chan_b_on, subsys_on, link_b_samples_valid;
  int failures = 0;
  int comparisons = 0;
  link_status_regs i_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .link_up(link_up),
    .sync_n(sync_n),
    .sysref_evt(sysref_evt),
    .phase_shift_evt(phase_shift_evt),
    .pll_locked(pll_locked),
    .b_on_link_a(b_on_link_a),
    .serial_link_enable(serial_link_enable),
    .chan_a_power_off(chan_a_power_off),
    .chan_b_power_off(chan_b_power_off),
    .chan_a_on(chan_a_on),
    .chan_b_on(chan_b_on),
    .subsys_on(subsys_on),
    .link_b_samples_valid(link_b_samples_valid)
  );
  rx_model i_rx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .serial_link_enable(serial_link_enable),
    .link_up(link_up),
    .sync_n(sync_n),
    .sysref_evt(sysref_evt),
    .phase_shift_evt(phase_shift_evt),
    .pll_locked(pll_locked),
    .b_on_link_a(b_on_link_a)
  );
  initial
  begin
    forever #50 clk_sys = !clk_sys;
  end
  task automatic test_done;
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    chk("rdata", reg_rdata, e);
  endtask
  task automatic pw(input logic [7:0] d, input logic [2:0] e);
    wr(12'h0209, d);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("power", {5'h00, chan_a_on, chan_b_on, subsys_on}, {5'h00, e});
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    rd(12'h0209, 8'h00);
    rd(12'h0208, 8'h04);
    wr(12'h020F, 8'hFF);
    rd(12'h020F, 8'h00);
  endtask
  task automatic t_flags;
    wr(12'h020C, 8'h01);
    for (int i = 0; i < 20 && link_up !== 1'h1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk("enable", {7'h00, serial_link_enable}, 8'h01);
    rd(12'h0208, 8'h64);
    i_rx.pulse(1'h1);
    rd(12'h0208, 8'h6C);
    wr(12'h0208, 8'h08);
    i_rx.pulse(1'h1);
    rd(12'h0208, 8'h64);
    i_rx.pulse(1'h0);
    rd(12'h0208, 8'h74);
    wr(12'h0208, 8'h00);
    wr(12'h0208, 8'h44);
    rd(12'h0208, 8'h74);
    wr(12'h0208, 8'h10);
    rd(12'h0208, 8'h64);
  endtask
  task automatic t_pll;
    @(posedge clk_sys);
    i_rx.pll_locked <= 1'h0;
    rd(12'h0208, 8'h20);
    i_rx.pll_locked <= 1'h1;
  endtask
  task automatic t_power;
    wr(12'h020C, 8'h00);
    i_rx.b_on_link_a <= 1'h1;
    pw(8'h02, 3'h5);
    chk("b_valid", {7'h00, link_b_samples_valid}, 8'h00);
    rd(12'h0209, 8'h02);
    pw(8'h01, 3'h3);
    pw(8'h03, 3'h0);
    rd(12'h0208, 8'h00);
    pw(8'h00, 3'h7);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_reset;
    t_flags;
    t_pll;
    t_power;
    test_done;
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    test_done;
  end
endmodule // testbench

bind link_status_regs link_checker i_chk (.*);
